// ---- rtl/config_prom_output_control.sv ----
// Control inputs, address sequencing and output enables of the configuration memory
`timescale 1ns/1ps
`default_nettype none
module config_prom_output_control
#(
  parameter logic [cfg_out_pkg::ADDR_W-1:0] HIGHEST_ADDRESS = cfg_out_pkg::HIGHEST_ADDRESS_DEF
)
(
  input  wire logic                           core_clk_in,
  input  wire logic                           rst_n_in,
  input  wire logic                           chip_enable_n_in,
  input  wire logic                           oe_reset_n_in,
  input  wire logic                           config_pulse_n_in,
  input  wire logic                           stall_in,
  input  wire logic                           link_clk_in,
  input  wire logic                           parallel_mode_in,
  input  wire logic                           decompress_en_in,
  input  wire logic                           revision_en_in,
  input  wire logic [1:0]                     revision_sel_in,
  input  wire logic [cfg_out_pkg::ADDR_W-1:0] revision_start_in,
  input  wire logic [cfg_out_pkg::ADDR_W-1:0] revision_end_address_in,
  output logic [cfg_out_pkg::ADDR_W-1:0]      mem_addr_out,
  output logic [1:0]                          revision_latched_out,
  output logic                                data_oe_out,
  output logic                                forwarded_clock_oe_out,
  output logic                                data_advance_out,
  output logic                                cascade_out_n_out,
  output logic                                standby_out
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [cfg_out_pkg::SYNC_STAGES-1:0] ce_s_r;
  logic [cfg_out_pkg::SYNC_STAGES-1:0] oe_s_r;
  logic [cfg_out_pkg::SYNC_STAGES-1:0] cf_s_r;
  logic [cfg_out_pkg::SYNC_STAGES-1:0] st_s_r;
  logic [cfg_out_pkg::SYNC_STAGES-1:0] lk_s_r;
  logic                                cf_d_r;
  logic                                lk_d_r;

  // Pins reset to their idle level, output-enable reset to its active level, so no false edge appears on release
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ce_s_r <= 2'h3;
      oe_s_r <= 2'h0;
      cf_s_r <= 2'h3;
      st_s_r <= 2'h0;
      lk_s_r <= 2'h0;
      cf_d_r <= 1'b1;
      lk_d_r <= 1'b0;
    end
    else
    begin
      ce_s_r <= {ce_s_r[0], chip_enable_n_in};
      oe_s_r <= {oe_s_r[0], oe_reset_n_in};
      cf_s_r <= {cf_s_r[0], config_pulse_n_in};
      st_s_r <= {st_s_r[0], stall_in};
      lk_s_r <= {lk_s_r[0], link_clk_in};
      cf_d_r <= cf_s_r[1];
      lk_d_r <= lk_s_r[1];
    end
  end

  logic ce_n;
  logic oe_n;
  logic cf_hi;
  logic cf_rise;
  logic lk_rise;
  logic stall_ok;
  logic any_reset;
  logic at_top;
  logic at_end;
  logic [cfg_out_pkg::ADDR_W-1:0] start_addr;

  cfg_out_if ctr_if ();

  assign ce_n      = ce_s_r[1];
  assign oe_n      = !oe_s_r[1];
  assign cf_hi     = cf_s_r[1];
  assign cf_rise   = cf_s_r[1] && !cf_d_r;
  assign lk_rise   = lk_s_r[1] && !lk_d_r; // R14
  // Stall counts only for parallel output without decompression
  assign stall_ok  = st_s_r[1] && parallel_mode_in && !decompress_en_in; // R9
  assign any_reset = ce_n || oe_n; // R1 R12
  assign at_top    = ctr_if.addr == HIGHEST_ADDRESS;
  // Revision end applies only with revisioning and in the parallel variant
  assign at_end    = parallel_mode_in && revision_en_in
                     && ctr_if.addr == revision_end_address_in; // R11
  assign start_addr = revision_en_in ? revision_start_in : cfg_out_pkg::ADDR_RESET; // R10

  // ****************************************************************
  // Address control
  // ****************************************************************
  always_comb
  begin
    ctr_if.clr     = any_reset || cf_rise; // R2 R10 R12 R15
    ctr_if.clr_val = any_reset ? cfg_out_pkg::ADDR_RESET : start_addr;
    ctr_if.step    = lk_rise && !at_top && !at_end && !stall_ok
                     && (!parallel_mode_in || cf_hi); // R4 R6 R7 R8
  end

  cfg_addr_counter u_counter
  (
    .clk_in   (core_clk_in),
    .rst_n_in (rst_n_in),
    .ctr      (ctr_if.cnt)
  );

  // ****************************************************************
  // Revision selection sample
  // ****************************************************************
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      revision_latched_out <= 2'h0;
    else if (cf_rise && !ce_n)
      revision_latched_out <= revision_sel_in; // R13
  end

  // ****************************************************************
  // Output drive
  // ****************************************************************
  // A stall keeps outputs driven even past the end, matching the frozen word
  logic drive_nxt;
  assign drive_nxt = !any_reset && (cf_rise || stall_ok || (!at_top && !at_end));

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      data_oe_out            <= 1'b0;
      forwarded_clock_oe_out <= 1'b0;
      cascade_out_n_out      <= 1'b1;
      standby_out            <= 1'b1;
      data_advance_out       <= 1'b0;
      mem_addr_out           <= cfg_out_pkg::ADDR_RESET;
    end
    else
    begin
      data_oe_out            <= drive_nxt; // R4 R5 R7 R8 R9
      forwarded_clock_oe_out <= drive_nxt && parallel_mode_in; // R6 R7 R8
      cascade_out_n_out      <= !(!any_reset && at_top && !stall_ok); // R2 R5 R8
      standby_out            <= ce_n; // R1 R2
      data_advance_out       <= ctr_if.step; // R14
      mem_addr_out           <= ctr_if.addr;
    end
  end

  a_standby_float: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    ce_n |=> (!data_oe_out && cascade_out_n_out && standby_out)) // R2
    else $error("standby did not float outputs");
  a_oe_reset_addr: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    oe_n |=> ctr_if.addr == cfg_out_pkg::ADDR_RESET) // R12
    else $error("output enable low did not reset address");
  a_top_cascade: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (!any_reset && at_top && !stall_ok) |=> !cascade_out_n_out) // R5
    else $error("cascade not low at highest address");
  a_end_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (at_end && !any_reset && !cf_rise) |=> $stable(ctr_if.addr)) // R7
    else $error("address moved past revision end");
  a_pulse_start: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (cf_rise && !any_reset) |=> ctr_if.addr == $past(start_addr)) // R10
    else $error("pulse edge did not load start address");
  a_stall_freeze: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (stall_ok && !any_reset && !cf_rise) |=> ($stable(ctr_if.addr) && data_oe_out)) // R9
    else $error("stall did not freeze address");
  a_rev_sample: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (cf_rise && !ce_n) |=> revision_latched_out == $past(revision_sel_in)) // R13
    else $error("revision selection not sampled");
  a_run_step: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (lk_rise && !any_reset && !cf_rise && !at_top && !at_end && !stall_ok
     && (!parallel_mode_in || cf_hi)) |=> ctr_if.addr == $past(ctr_if.addr) + 1'b1) // R4
    else $error("address did not advance on link clock");
  a_par_clock_float: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (parallel_mode_in && at_top && !any_reset && !stall_ok && !cf_rise)
    |=> (!forwarded_clock_oe_out && !data_oe_out)) // R8
    else $error("forwarded clock driven at highest address");
endmodule
`default_nettype wire

// ---- rtl/cfg_out_pkg.sv ----
// Constants and types for the configuration memory output control block
// Notes on behaviour
// R1 - Chip enable high puts the device into low-power standby.
// R2 - Standby holds address reset, cascade output high, other outputs floating.
// R3 - Controller keeps test pins high and test clock static for standby; neither the code nor the model has test pins or a test clock.
// R4 - Serial: below highest address, advance address, drive data, cascade high.
// R5 - Serial: at highest address, hold, float data, drive cascade output low.
// R6 - Parallel: pulse high, stall low, below both limits: advance, drive data, clock.
// R7 - Parallel: at revision end below highest: hold, float, cascade stays high.
// R8 - Parallel: at highest address: hold, float data and clock, cascade low.
// R9 - Stall freezes address and data; honoured only parallel, no decompression.
// R10 - Pulse rising edge resets address to revision start or zero.
// R11 - With revisioning, revision end address stops counting; the code stops there only in parallel mode.
// R12 - Output-enable low resets address, cascade high, others float.
// R13 - Revision selection resampled on pulse rising edge while chip enabled.
// R14 - Address and data advance once per link clock edge.
// R15 - Address held at reset value while any reset lasts, then counts.
package cfg_out_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;
  localparam logic [ADDR_W-1:0] HIGHEST_ADDRESS_DEF = 24'hFFFFFF;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_RESET,
    ST_RUN,
    ST_DONE
  } ctl_state_e;

endpackage

// ---- rtl/cfg_out_if.sv ----
// Interface between the control core and the address counter
`timescale 1ns/1ps
`default_nettype none
interface cfg_out_if;
  logic                              clr;
  logic [cfg_out_pkg::ADDR_W-1:0]    clr_val;
  logic                              step;
  logic [cfg_out_pkg::ADDR_W-1:0]    addr;

  modport ctl (output clr, output clr_val, output step, input addr);
  modport cnt (input clr, input clr_val, input step, output addr);
endinterface
`default_nettype wire

// ---- rtl/cfg_addr_counter.sv ----
// Address counter with synchronous clear and step
`timescale 1ns/1ps
`default_nettype none
module cfg_addr_counter
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  cfg_out_if.cnt    ctr
);
  logic [cfg_out_pkg::ADDR_W-1:0] addr_r;

  assign ctr.addr = addr_r;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      addr_r <= cfg_out_pkg::ADDR_RESET;
    else if (ctr.clr)
      addr_r <= ctr.clr_val; // R15
    else if (ctr.step)
      addr_r <= addr_r + 1'b1; // R14
  end

  a_clear_wins: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ctr.clr |=> addr_r == $past(ctr.clr_val)) // R15
    else $error("counter did not take clear value");
  a_step_once: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!ctr.clr && ctr.step) |=> addr_r == $past(addr_r) + 1'b1) // R14
    else $error("counter did not step by one");
  a_hold_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!ctr.clr && !ctr.step) |=> $stable(addr_r)) // R9
    else $error("counter moved without a step");
endmodule
`default_nettype wire

// ---- verification/fpga_cfg_model.sv ----
// Far-side model: configuration logic that clocks, pulses and stalls the memory
`timescale 1ns/1ps
`default_nettype none
module fpga_cfg_model
(
  output logic link_clk_out,
  output logic config_pulse_n_out,
  output logic stall_out
);
  // Link clock idles low between frames; pulse idles high, stall idles low
  initial
  begin
    link_clk_out       = 1'b0;
    config_pulse_n_out = 1'b1;
    stall_out          = 1'b0;
  end

  task automatic clocks(input int n);
    repeat (n)
    begin
      #100 link_clk_out = 1'b1;
      #100 link_clk_out = 1'b0;
    end
  endtask

  task automatic pulse();
    config_pulse_n_out = 1'b0;
    #400 config_pulse_n_out = 1'b1;
  endtask

  task automatic hold(input logic s);
    stall_out = s;
  endtask
endmodule
`default_nettype wire

// ---- verification/config_prom_output_control_tb_top.sv ----
// Self-checking bench for the configuration memory output control
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected at %0t got %0h exp %0h", $time, (g), (e)); end end
module config_prom_output_control_tb_top;
  localparam logic [23:0] TOP = 24'h000010;
  logic core_clk_in = 1'b0, rst_n_in = 1'b0, ce_n = 1'b1, oe_n = 1'b0;
  logic par = 1'b0, dec = 1'b0, rev = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [23:0] st = 24'h000000, ea = 24'h000000;
  wire logic lclk, cf_n, stall, doe, coe, adv, casc, sb;
  wire logic [23:0] addr;
  wire logic [1:0] rl;
  int err_count = 0, comparisons = 0, k, adv_cnt = 0, a0 = 0;

  always #12.5 core_clk_in = ~core_clk_in;

  // Step pulses are counted away from the edge that launches them
  always @(negedge core_clk_in)
    if (adv !== 1'b0)
      adv_cnt++;

  fpga_cfg_model fpga_cfg_model_i (.link_clk_out(lclk), .config_pulse_n_out(cf_n),
    .stall_out(stall));

  config_prom_output_control #(.HIGHEST_ADDRESS(TOP)) config_prom_output_control_i (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .chip_enable_n_in(ce_n),
    .oe_reset_n_in(oe_n), .config_pulse_n_in(cf_n), .stall_in(stall),
    .link_clk_in(lclk), .parallel_mode_in(par), .decompress_en_in(dec),
    .revision_en_in(rev), .revision_sel_in(sel), .revision_start_in(st),
    .revision_end_address_in(ea), .mem_addr_out(addr), .revision_latched_out(rl),
    .data_oe_out(doe), .forwarded_clock_oe_out(coe), .data_advance_out(adv),
    .cascade_out_n_out(casc), .standby_out(sb));

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  function automatic logic [23:0] lim(input logic [23:0] s, input int n,
                                      input logic [23:0] l);
    return ((s + n) > l) ? l : 24'(s + n);
  endfunction

  task automatic chk_out(input string nm, input logic [23:0] a, input logic d,
                         input logic c);
    wt(8);
    `CHK(addr, a)
    `CHK(doe, d)
    `CHK(casc, c)
    $display("test %s done", nm);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    k = $urandom(99);
    wt(20);
    rst_n_in = 1'b1;
    oe_n = 1'b1;
    // Straps and stall at random: standby must override all of them
    par = 1'($urandom_range(0, 1));
    dec = 1'($urandom_range(0, 1));
    rev = 1'($urandom_range(0, 1));
    fpga_cfg_model_i.hold(1'($urandom_range(0, 1)));
    fpga_cfg_model_i.clocks(5);
    chk_out("standby", 24'h000000, 1'b0, 1'b1);
    `CHK(sb, 1'b1)
    `CHK(coe, 1'b0)
    // Serial: a random stall level must be ignored
    par = 1'b0;
    ce_n = 1'b0;
    wt(4);
    a0 = adv_cnt;
    k = $urandom_range(3, 12);
    fpga_cfg_model_i.clocks(k);
    chk_out("serial count", lim(24'h000000, k, TOP), 1'b1, 1'b1);
    `CHK(adv_cnt - a0, k)
    `CHK(sb, 1'b0)
    `CHK(coe, 1'b0)
    fpga_cfg_model_i.clocks(20);
    chk_out("serial top", TOP, 1'b0, 1'b0);
    oe_n = 1'b0;
    fpga_cfg_model_i.clocks(2);
    chk_out("oe reset", 24'h000000, 1'b0, 1'b1);
    oe_n = 1'b1;
    wt(4);
    fpga_cfg_model_i.clocks(2);
    chk_out("oe release", 24'h000002, 1'b1, 1'b1);
    // Parallel with revisioning: reload, count to the revision end
    fpga_cfg_model_i.hold(1'b0);
    par = 1'b1;
    dec = 1'b0;
    rev = 1'b1;
    // Random revision window kept well below the highest address
    st = 24'($urandom_range(1, 4));
    ea = st + 24'($urandom_range(7, 10));
    sel = 2'($urandom_range(0, 3));
    fpga_cfg_model_i.pulse();
    chk_out("reload", st, 1'b1, 1'b1);
    `CHK(rl, sel)
    k = $urandom_range(1, 4);
    fpga_cfg_model_i.clocks(k);
    chk_out("parallel count", lim(st, k, ea), 1'b1, 1'b1);
    `CHK(coe, 1'b1)
    fpga_cfg_model_i.clocks(10);
    chk_out("revision end", ea, 1'b0, 1'b1);
    `CHK(coe, 1'b0)
    fpga_cfg_model_i.pulse();
    fpga_cfg_model_i.clocks(2);
    fpga_cfg_model_i.hold(1'b1);
    a0 = adv_cnt;
    fpga_cfg_model_i.clocks(3);
    chk_out("stall", st + 24'h000002, 1'b1, 1'b1);
    `CHK(adv_cnt - a0, 0)
    dec = 1'b1;
    fpga_cfg_model_i.clocks(3);
    chk_out("stall ignored", st + 24'h000005, 1'b1, 1'b1);
    fpga_cfg_model_i.hold(1'b0);
    dec = 1'b0;
    rev = 1'b0;
    fpga_cfg_model_i.pulse();
    fpga_cfg_model_i.clocks(20);
    chk_out("parallel top", TOP, 1'b0, 1'b0);
    `CHK(coe, 1'b0)
    end_sim();
  end

  // Roughly ten times the expected run length
  initial
  begin
    #200000;
    err_count++;
    end_sim();
  end
endmodule
`default_nettype wire
